// file: logic/switch_port_config_regs.sv
`timescale 1ns/1ns
// What this block does
// RULE_01 - capability header low byte reads fixed 0x0d
// RULE_02 - next pointer bits 15:8, reset zero, written only when lock open
// RULE_03 - vendor code 15:0 and subsystem code 31:16, lock-writable, reset zero
// RULE_04 - pointer bits 7:2 pick the dword; bits 1:0 read zero
// RULE_05 - pointer bits 11:8 pick the extended number; bits 31:12 read zero
// RULE_06 - window read returns the register the pointer selects
// RULE_07 - window write lands in the register the pointer selects
// RULE_08 - window byte enables are passed to the target access
// RULE_09 - pointer at the window itself: reads zero, writes dropped
// RULE_10 - pointer at itself: window writes update the pointer
// RULE_11 - sideband window reads return zero, sideband writes do nothing
// RULE_12 - error header: id 0x1, version 0x1, lockable next 0x200
// RULE_13 - detected errors set their status flags
// RULE_14 - surprise down flag held zero unless link reports the capability
// RULE_15 - completion timeout flag is always zero
// RULE_16 - completer abort flag is always zero
// RULE_17 - obsolete bit 0 and reserved ranges read zero
// RULE_18 - flags clear on write of one, survive all but power-on reset
// RULE_19 - masked events are neither logged nor reported
module switch_port_config_regs (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_por_b,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic i_sideband,
  input wire logic [11:0] i_addr,
  input wire logic [3:0] i_be,
  input wire logic [31:0] i_wdata,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic o_ext_req,
  output logic o_ext_wr,
  output logic [11:0] o_ext_addr,
  output logic [3:0] o_ext_be,
  output logic [31:0] o_ext_wdata,
  input wire logic i_ext_ack,
  input wire logic [31:0] i_ext_rdata,
  input wire logic i_lock_wr_en,
  input wire logic [31:0] i_err_event,
  input wire logic [31:0] i_uncorr_mask,
  input wire logic i_sd_report_capable,
  output logic o_uncorr_report
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    merge = (old_v & ~be_mask(be)) | (new_v & be_mask(be));
  endfunction : merge

  function automatic logic is_local(input logic [11:0] a);
    is_local = (a == cfg_regs_pkg::SSCAP_OFF) || (a == cfg_regs_pkg::SUBSYS_ID_OFF) ||
               (a == cfg_regs_pkg::PTR_OFF) || (a == cfg_regs_pkg::ERR_HDR_OFF) ||
               (a == cfg_regs_pkg::UES_OFF);
  endfunction : is_local

  // ----------------------------------------
  // resets
  // ----------------------------------------
  logic rst_b;
  logic por_b;

  rst_release u_rst (
    .i_clk(i_mclk),
    .i_arst_b(i_rst_b),
    .o_rst_b(rst_b)
  );

  rst_release u_por (
    .i_clk(i_mclk),
    .i_arst_b(i_por_b),
    .o_rst_b(por_b)
  );

  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  cfg_regs_pkg::seq_state_e state_reg;
  logic [7:0] ss_next_reg;
  logic [31:0] subsys_id_reg;
  logic [31:0] ptr_reg;
  logic [11:0] aer_next_reg;
  logic [31:0] flags;
  logic [31:0] flag_clear;
  logic is_win;
  logic [11:0] tgt;
  logic drop;
  logic req_go;
  logic loc_hit;
  logic loc_wr;
  logic ext_go;
  logic [31:0] tgt_old;
  logic [31:0] wr_val;
  logic [31:0] rd_val;

  always_comb begin
    is_win = i_addr[11:2] == cfg_regs_pkg::WIN_OFF[11:2];
    tgt = is_win ? {ptr_reg[11:2], 2'b00} : {i_addr[11:2], 2'b00}; // RULE_04 RULE_05
    drop = is_win && (i_sideband || tgt == cfg_regs_pkg::WIN_OFF); // RULE_09 RULE_11
    req_go = i_req && (state_reg == cfg_regs_pkg::ST_IDLE);
    loc_hit = is_local(tgt);
    loc_wr = req_go && i_wr && !drop && loc_hit; // RULE_07
    ext_go = req_go && is_win && !drop && !loc_hit; // RULE_06 RULE_07
  end

  always_comb begin
    case (tgt)
      cfg_regs_pkg::SSCAP_OFF: tgt_old = {16'h0000, ss_next_reg, cfg_regs_pkg::SS_CAP_ID}; // RULE_01
      cfg_regs_pkg::SUBSYS_ID_OFF: tgt_old = subsys_id_reg;
      cfg_regs_pkg::PTR_OFF: tgt_old = ptr_reg & cfg_regs_pkg::PTR_WMASK; // RULE_04 RULE_05
      cfg_regs_pkg::ERR_HDR_OFF: begin
        tgt_old = {aer_next_reg, cfg_regs_pkg::AER_CAP_VER, cfg_regs_pkg::AER_CAP_ID}; // RULE_12
      end
      cfg_regs_pkg::UES_OFF: tgt_old = flags; // RULE_15 RULE_16 RULE_17
      default: tgt_old = 32'h0000_0000;
    endcase
    wr_val = merge(tgt_old, i_wdata, i_be); // RULE_08
    rd_val = (drop || !loc_hit) ? 32'h0000_0000 : (tgt_old & be_mask(i_be)); // RULE_06 RULE_08
    flag_clear = (loc_wr && tgt == cfg_regs_pkg::UES_OFF) ? (i_wdata & be_mask(i_be))
                                                           : 32'h0000_0000; // RULE_18
  end

  // ----------------------------------------
  // writable fields
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      ss_next_reg <= cfg_regs_pkg::SS_NEXT_RST;
    end else if (loc_wr && tgt == cfg_regs_pkg::SSCAP_OFF && i_lock_wr_en) begin
      ss_next_reg <= wr_val[15:8]; // RULE_02
    end
  end

  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      subsys_id_reg <= cfg_regs_pkg::SUBSYS_ID_RST;
    end else if (loc_wr && tgt == cfg_regs_pkg::SUBSYS_ID_OFF && i_lock_wr_en) begin
      subsys_id_reg <= wr_val; // RULE_03
    end
  end

  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_reg <= cfg_regs_pkg::PTR_RST;
    end else if (loc_wr && tgt == cfg_regs_pkg::PTR_OFF) begin
      ptr_reg <= wr_val & cfg_regs_pkg::PTR_WMASK; // RULE_10
    end
  end

  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      aer_next_reg <= cfg_regs_pkg::AER_NEXT_RST;
    end else if (loc_wr && tgt == cfg_regs_pkg::ERR_HDR_OFF && i_lock_wr_en) begin
      aer_next_reg <= wr_val[31:20]; // RULE_12
    end
  end

  // ----------------------------------------
  // status flags, kept on the power-on reset
  // ----------------------------------------
  err_flag_bank u_flags (
    .i_clk(i_mclk),
    .i_rst_b(por_b),
    .i_event(i_err_event),
    .i_mask(i_uncorr_mask),
    .i_clear(flag_clear),
    .i_sd_capable(i_sd_report_capable),
    .o_flags(flags),
    .o_report(o_uncorr_report)
  );

  // ----------------------------------------
  // answer sequencer
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cfg_regs_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        cfg_regs_pkg::ST_IDLE: begin
          if (ext_go) begin
            state_reg <= cfg_regs_pkg::ST_EXT;
          end
        end
        cfg_regs_pkg::ST_EXT: begin
          if (i_ext_ack) begin
            state_reg <= cfg_regs_pkg::ST_IDLE;
          end
        end
        default: state_reg <= cfg_regs_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else if (req_go && !ext_go) begin
      o_ack <= 1'b1;
      o_rdata <= i_wr ? 32'h0000_0000 : rd_val;
    end else if (state_reg == cfg_regs_pkg::ST_EXT && i_ext_ack) begin
      o_ack <= 1'b1;
      o_rdata <= i_ext_rdata; // RULE_06
    end else begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end
  end

  // forward window accesses that fall outside this bank
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      o_ext_req <= 1'b0;
      o_ext_wr <= 1'b0;
      o_ext_addr <= 12'h000;
      o_ext_be <= 4'h0;
      o_ext_wdata <= 32'h0000_0000;
    end else if (ext_go) begin
      o_ext_req <= 1'b1;
      o_ext_wr <= i_wr; // RULE_07
      o_ext_addr <= tgt;
      o_ext_be <= i_be; // RULE_08
      o_ext_wdata <= i_wdata;
    end else begin
      o_ext_req <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_cap_id;
    @(posedge i_mclk) disable iff (!rst_b)
      req_go && !i_wr && !drop && tgt == cfg_regs_pkg::SSCAP_OFF && i_be[0]
      |=> o_ack && o_rdata[7:0] == 8'h0d;
  endproperty
  a_cap_id: assert property (p_cap_id) else $error("capability id wrong"); // RULE_01

  property p_ptr_reserved;
    @(posedge i_mclk) disable iff (!rst_b)
      ptr_reg[1:0] == 2'b00 && ptr_reg[31:12] == 20'h00000;
  endproperty
  a_ptr_reserved: assert property (p_ptr_reserved) else $error("pointer reserved set"); // RULE_05

  property p_self_zero;
    @(posedge i_mclk) disable iff (!rst_b)
      req_go && !i_wr && drop |=> o_ack && o_rdata == 32'h0000_0000;
  endproperty
  a_self_zero: assert property (p_self_zero) else $error("dropped read not zero"); // RULE_09

  property p_ptr_self;
    @(posedge i_mclk) disable iff (!rst_b)
      req_go && i_wr && is_win && !i_sideband && tgt == cfg_regs_pkg::PTR_OFF && i_be == 4'hf
      |=> ptr_reg == ($past(i_wdata) & 32'h0000_0ffc);
  endproperty
  a_ptr_self: assert property (p_ptr_self) else $error("pointer self write lost"); // RULE_10

  property p_sideband;
    @(posedge i_mclk) disable iff (!rst_b)
      req_go && is_win && i_sideband
      |=> !o_ext_req && o_rdata == 32'h0000_0000 && ptr_reg == $past(ptr_reg)
          && subsys_id_reg == $past(subsys_id_reg);
  endproperty
  a_sideband: assert property (p_sideband) else $error("sideband window acted"); // RULE_11

  property p_forward;
    @(posedge i_mclk) disable iff (!rst_b)
      ext_go |=> o_ext_req && o_ext_wr == $past(i_wr) && o_ext_be == $past(i_be)
                 && o_ext_addr == {$past(ptr_reg[11:2]), 2'b00} ##1 !o_ext_req;
  endproperty
  a_forward: assert property (p_forward) else $error("forward wrong"); // RULE_08

  property p_aer_hdr;
    @(posedge i_mclk) disable iff (!rst_b)
      req_go && !i_wr && !drop && tgt == cfg_regs_pkg::ERR_HDR_OFF && i_be == 4'hf
      |=> o_rdata[19:0] == 20'h10001;
  endproperty
  a_aer_hdr: assert property (p_aer_hdr) else $error("error header wrong"); // RULE_12

  property p_lock;
    @(posedge i_mclk) disable iff (!rst_b)
      !i_lock_wr_en |=> subsys_id_reg == $past(subsys_id_reg)
          && ss_next_reg == $past(ss_next_reg) && aer_next_reg == $past(aer_next_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked field written"); // RULE_03

  property p_ext_answer;
    @(posedge i_mclk) disable iff (!rst_b)
      state_reg == cfg_regs_pkg::ST_EXT && i_ext_ack
      |=> o_ack && o_rdata == $past(i_ext_rdata) && state_reg == cfg_regs_pkg::ST_IDLE;
  endproperty
  a_ext_answer: assert property (p_ext_answer) else $error("forwarded answer lost"); // RULE_06

  property p_unmapped;
    @(posedge i_mclk) disable iff (!rst_b)
      req_go && !is_win && !loc_hit |=> o_ack && o_rdata == 32'h0000_0000 && !o_ext_req;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access acted");
endmodule : switch_port_config_regs

// file: logic/cfg_regs_pkg.sv
package cfg_regs_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] SSCAP_OFF = 12'h0f0;
  localparam logic [11:0] SUBSYS_ID_OFF = 12'h0f4;
  localparam logic [11:0] PTR_OFF = 12'h0f8;
  localparam logic [11:0] WIN_OFF = 12'h0fc;
  localparam logic [11:0] ERR_HDR_OFF = 12'h100;
  localparam logic [11:0] UES_OFF = 12'h104;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam logic [7:0] SS_CAP_ID = 8'h0d;
  localparam logic [7:0] SS_NEXT_RST = 8'h00;
  localparam logic [31:0] SUBSYS_ID_RST = 32'h0000_0000;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [31:0] PTR_WMASK = 32'h0000_0ffc;
  localparam logic [15:0] AER_CAP_ID = 16'h0001;
  localparam logic [3:0] AER_CAP_VER = 4'h1;
  localparam logic [11:0] AER_NEXT_RST = 12'h200;
  localparam logic [31:0] UES_RST = 32'h0000_0000;
  // flags that hardware can set: 4,5,12,13,16..20
  localparam logic [31:0] UES_SETTABLE = 32'h001f_3030;
  localparam logic [31:0] UES_SD_BIT = 32'h0000_0020;
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXT = 2'b01
  } seq_state_e;
endpackage : cfg_regs_pkg

// file: logic/rst_release.sv
`timescale 1ns/1ns
module rst_release (
  input wire logic i_clk,
  input wire logic i_arst_b,
  output logic o_rst_b
);
  logic stage_reg;

  // assert at once, release after two edges
  always_ff @(posedge i_clk or negedge i_arst_b) begin
    if (!i_arst_b) begin
      stage_reg <= 1'b0;
      o_rst_b <= 1'b0;
    end else begin
      stage_reg <= 1'b1;
      o_rst_b <= stage_reg;
    end
  end
endmodule : rst_release

// file: logic/err_flag_bank.sv
`timescale 1ns/1ns
module err_flag_bank (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [31:0] i_event,
  input wire logic [31:0] i_mask,
  input wire logic [31:0] i_clear,
  input wire logic i_sd_capable,
  output logic [31:0] o_flags,
  output logic o_report
);
  logic [31:0] keep;
  logic [31:0] set_vec;

  always_comb begin
    keep = i_sd_capable ? 32'hffff_ffff : ~cfg_regs_pkg::UES_SD_BIT; // RULE_14
    set_vec = i_event & ~i_mask & cfg_regs_pkg::UES_SETTABLE & keep; // RULE_13 RULE_19
  end

  // sticky: only the power-on reset reaches here; set beats clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flags <= cfg_regs_pkg::UES_RST;
    end else begin
      o_flags <= ((o_flags & ~i_clear) | set_vec) & keep; // RULE_18
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_report <= 1'b0;
    end else begin
      o_report <= |set_vec; // RULE_19
    end
  end

  property p_set_wins;
    @(posedge i_clk) disable iff (!i_rst_b)
      set_vec[4] && i_clear[4] |=> o_flags[4];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear"); // RULE_18

  property p_masked;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_event[12] && i_mask[12] && !o_flags[12] |=> !o_flags[12];
  endproperty
  a_masked: assert property (p_masked) else $error("masked event logged"); // RULE_19

  property p_fixed_zero;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_flags[15:14] == 2'b00 && o_flags[3:0] == 4'h0 && o_flags[31:21] == 11'h000;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bit set"); // RULE_15

  property p_sd_gate;
    @(posedge i_clk) disable iff (!i_rst_b)
      !i_sd_capable |=> !o_flags[5];
  endproperty
  a_sd_gate: assert property (p_sd_gate) else $error("surprise down set"); // RULE_14
endmodule : err_flag_bank

// file: dv/tb_switch_port_config_regs.sv
`timescale 1ns/1ns
module tb_switch_port_config_regs;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_por_b = 1'b0;
  logic i_req = 1'b0;
  logic i_wr = 1'b0;
  logic i_sideband = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [3:0] i_be = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_ext_ack = 1'b0;
  logic [31:0] i_ext_rdata = 32'h0;
  logic i_lock_wr_en = 1'b0;
  logic [31:0] i_err_event = 32'h0;
  logic [31:0] i_uncorr_mask = 32'h0;
  logic i_sd_report_capable = 1'b0;
  logic o_ack;
  logic [31:0] o_rdata;
  logic o_ext_req;
  logic o_ext_wr;
  logic [11:0] o_ext_addr;
  logic [3:0] o_ext_be;
  logic [31:0] o_ext_wdata;
  logic o_uncorr_report;
  int failures = 0;
  int num_checks = 0;
  int ext_count = 0;
  logic [31:0] ext_data = 32'h0;
  logic ext_wr_q = 1'b0;
  logic [11:0] ext_addr_q = 12'h000;
  logic [3:0] ext_be_q = 4'h0;
  logic [31:0] ext_wdata_q = 32'h0;
  logic [31:0] rd;
  logic [31:0] flags_exp;
  int bits [9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};

  always #50 i_mclk = ~i_mclk;

  switch_port_config_regs dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_por_b(i_por_b), .i_req(i_req), .i_wr(i_wr),
    .i_sideband(i_sideband), .i_addr(i_addr), .i_be(i_be), .i_wdata(i_wdata),
    .o_ack(o_ack), .o_rdata(o_rdata), .o_ext_req(o_ext_req), .o_ext_wr(o_ext_wr),
    .o_ext_addr(o_ext_addr), .o_ext_be(o_ext_be), .o_ext_wdata(o_ext_wdata),
    .i_ext_ack(i_ext_ack), .i_ext_rdata(i_ext_rdata), .i_lock_wr_en(i_lock_wr_en),
    .i_err_event(i_err_event), .i_uncorr_mask(i_uncorr_mask),
    .i_sd_report_capable(i_sd_report_capable), .o_uncorr_report(o_uncorr_report)
  );

  // ----------------------------------------
  // far register space: answers one cycle after each forward
  // ----------------------------------------
  always @(posedge i_mclk) begin
    i_ext_ack <= 1'b0;
    if (o_ext_req === 1'b1) begin
      i_ext_ack <= 1'b1;
      i_ext_rdata <= ext_data;
      ext_count <= ext_count + 1;
      ext_wr_q <= o_ext_wr;
      ext_addr_q <= o_ext_addr;
      ext_be_q <= o_ext_be;
      ext_wdata_q <= o_ext_wdata;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic access(input logic wr, input logic sb, input logic [11:0] addr,
                        input logic [3:0] be, input logic [31:0] wd, output logic [31:0] q);
    int n;
    @(posedge i_mclk);
    i_req <= 1'b1;
    i_wr <= wr;
    i_sideband <= sb;
    i_addr <= addr;
    i_be <= be;
    i_wdata <= wd;
    @(posedge i_mclk);
    i_req <= 1'b0;
    for (n = 0; n < 20; n++) begin
      #1;
      if (o_ack === 1'b1) break;
      @(posedge i_mclk);
    end
    if (n == 20) begin
      failures++;
      $display("[ERR] answer wait expected ack seen none");
      give_verdict();
    end else begin
      q = o_rdata;
    end
  endtask : access

  task automatic wr_reg(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] t;
    access(1'b1, 1'b0, a, be, d, t);
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [3:0] be,
                        input logic [31:0] exp);
    logic [31:0] t;
    access(1'b0, 1'b0, a, be, 32'h0, t);
    check(name, t, exp);
  endtask : rd_chk

  task automatic pulse_event(input logic [31:0] ev, input logic exp_rep);
    @(posedge i_mclk);
    i_err_event <= ev;
    @(posedge i_mclk);
    i_err_event <= 32'h0;
    #1;
    check("report", {31'h0, o_uncorr_report}, {31'h0, exp_rep});
  endtask : pulse_event

  task automatic do_reset(input logic por);
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    i_por_b <= ~por;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    i_por_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask : do_reset

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    i_por_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
    rd_chk("sscap", cfg_regs_pkg::SSCAP_OFF, 4'hf, 32'h0000_000d);
    rd_chk("subsys id", cfg_regs_pkg::SUBSYS_ID_OFF, 4'hf, 32'h0);
    rd_chk("err hdr", cfg_regs_pkg::ERR_HDR_OFF, 4'hf, 32'h2001_0001);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, 32'h0);
    rd_chk("unmapped", 12'h200, 4'hf, 32'h0);
    // locked fields refuse writes while lock is closed
    wr_reg(cfg_regs_pkg::SUBSYS_ID_OFF, 4'hf, 32'hffff_ffff);
    rd_chk("subsys id", cfg_regs_pkg::SUBSYS_ID_OFF, 4'hf, 32'h0);
    wr_reg(cfg_regs_pkg::SSCAP_OFF, 4'hf, 32'hffff_ffff);
    rd_chk("sscap", cfg_regs_pkg::SSCAP_OFF, 4'hf, 32'h0000_000d);
    wr_reg(cfg_regs_pkg::ERR_HDR_OFF, 4'hf, 32'hffff_ffff);
    rd_chk("err hdr", cfg_regs_pkg::ERR_HDR_OFF, 4'hf, 32'h2001_0001);
    @(posedge i_mclk);
    i_lock_wr_en <= 1'b1;
    wr_reg(cfg_regs_pkg::SSCAP_OFF, 4'hf, 32'hffff_ffff);
    rd_chk("sscap", cfg_regs_pkg::SSCAP_OFF, 4'hf, 32'h0000_ff0d);
    wr_reg(cfg_regs_pkg::ERR_HDR_OFF, 4'hf, 32'hffff_ffff);
    rd_chk("err hdr", cfg_regs_pkg::ERR_HDR_OFF, 4'hf, 32'hfff1_0001);
    wr_reg(cfg_regs_pkg::PTR_OFF, 4'hf, 32'hffff_ffff);
    rd_chk("ptr", cfg_regs_pkg::PTR_OFF, 4'hf, 32'h0000_0ffc);
    // window aimed at the identification register
    wr_reg(cfg_regs_pkg::PTR_OFF, 4'hf, 32'h0000_00f4);
    wr_reg(cfg_regs_pkg::WIN_OFF, 4'hf, 32'h1234_5678);
    rd_chk("subsys id", cfg_regs_pkg::SUBSYS_ID_OFF, 4'hf, 32'h1234_5678);
    wr_reg(cfg_regs_pkg::WIN_OFF, 4'h1, 32'h5555_55aa);
    rd_chk("win", cfg_regs_pkg::WIN_OFF, 4'hf, 32'h1234_56aa);
    rd_chk("win", cfg_regs_pkg::WIN_OFF, 4'hc, 32'h1234_0000);
    access(1'b1, 1'b1, cfg_regs_pkg::WIN_OFF, 4'hf, 32'h0, rd);
    access(1'b0, 1'b1, cfg_regs_pkg::WIN_OFF, 4'hf, 32'h0, rd);
    check("sb win", rd, 32'h0);
    rd_chk("subsys id", cfg_regs_pkg::SUBSYS_ID_OFF, 4'hf, 32'h1234_56aa);
    // window aimed at itself, then at the pointer
    wr_reg(cfg_regs_pkg::PTR_OFF, 4'hf, 32'h0000_00fc);
    wr_reg(cfg_regs_pkg::WIN_OFF, 4'hf, 32'h0000_00f4);
    rd_chk("win", cfg_regs_pkg::WIN_OFF, 4'hf, 32'h0);
    rd_chk("ptr", cfg_regs_pkg::PTR_OFF, 4'hf, 32'h0000_00fc);
    check("fwd", ext_count, 0);
    wr_reg(cfg_regs_pkg::PTR_OFF, 4'hf, 32'h0000_00f8);
    wr_reg(cfg_regs_pkg::WIN_OFF, 4'hf, 32'h0000_0400);
    rd_chk("ptr", cfg_regs_pkg::PTR_OFF, 4'hf, 32'h0000_0400);
    // window aimed at the extended space
    wr_reg(cfg_regs_pkg::WIN_OFF, 4'h6, 32'hcafe_f00d);
    check("fwd count", ext_count, 1);
    check("fwd wr", {31'h0, ext_wr_q}, 32'h1);
    check("fwd addr", {20'h0, ext_addr_q}, 32'h400);
    check("fwd be", {28'h0, ext_be_q}, 32'h6);
    check("fwd wdata", ext_wdata_q, 32'hcafe_f00d);
    ext_data = 32'h89ab_cdef;
    rd_chk("win", cfg_regs_pkg::WIN_OFF, 4'hf, 32'h89ab_cdef);
    check("fwd wr", {31'h0, ext_wr_q}, 32'h0);
    check("fwd addr", {20'h0, ext_addr_q}, 32'h400);
    check("fwd be", {28'h0, ext_be_q}, 32'hf);
    // error flags
    @(posedge i_mclk);
    i_sd_report_capable <= 1'b1;
    flags_exp = 32'h0;
    foreach (bits[k]) begin
      pulse_event(32'h1 << bits[k], 1'b1);
      flags_exp = flags_exp | (32'h1 << bits[k]);
      rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, flags_exp);
    end
    pulse_event(~cfg_regs_pkg::UES_SETTABLE, 1'b0);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, flags_exp);
    wr_reg(cfg_regs_pkg::UES_OFF, 4'hf, 32'h0);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, flags_exp);
    wr_reg(cfg_regs_pkg::UES_OFF, 4'hf, 32'h0000_0010);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, flags_exp & 32'hffff_ffef);
    wr_reg(cfg_regs_pkg::UES_OFF, 4'hf, 32'hffff_ffff);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, 32'h0);
    // event and clear in one cycle: the event wins
    @(posedge i_mclk);
    i_err_event <= 32'h0000_0010;
    wr_reg(cfg_regs_pkg::UES_OFF, 4'hf, 32'h0000_0010);
    @(posedge i_mclk);
    i_err_event <= 32'h0;
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, 32'h0000_0010);
    wr_reg(cfg_regs_pkg::UES_OFF, 4'hf, 32'h0000_0010);
    @(posedge i_mclk);
    i_uncorr_mask <= 32'h0000_1000;
    pulse_event(32'h0000_1000, 1'b0);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, 32'h0);
    @(posedge i_mclk);
    i_uncorr_mask <= 32'h0;
    i_sd_report_capable <= 1'b0;
    pulse_event(32'h0000_2020, 1'b1);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, 32'h0000_2000);
    do_reset(1'b0);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, 32'h0000_2000);
    rd_chk("subsys id", cfg_regs_pkg::SUBSYS_ID_OFF, 4'hf, 32'h0);
    rd_chk("ptr", cfg_regs_pkg::PTR_OFF, 4'hf, 32'h0);
    do_reset(1'b1);
    rd_chk("flags", cfg_regs_pkg::UES_OFF, 4'hf, 32'h0);
    give_verdict();
  end
endmodule : tb_switch_port_config_regs
